/* File: logic/fcpc_defs.svh */
// offsets, field positions, reset values and timing counts of the fast conversion and pin block
`ifndef FCPC_DEFS_SVH
`define FCPC_DEFS_SVH

// register indices; byte address is four times the index
`define FCPC_IDX_DEBUG_CNT    8'hd5
`define FCPC_IDX_HB4_CTRL     8'he8
`define FCPC_IDX_CURSRC_PIN5  8'hf1
`define FCPC_IDX_PIN_DRIVE    8'hf2
`define FCPC_IDX_FAST_NEG     8'hf3
`define FCPC_IDX_FAST_POS     8'hf4
`define FCPC_IDX_FAST_CTRL    8'hf5
`define FCPC_IDX_RD_PTR       8'hfc

// field positions
`define FCPC_BIT_CONT_EN      0
`define FCPC_BIT_AUX_SEL      1
`define FCPC_BIT_FIRST_SEL    2
`define FCPC_BIT_SECOND_SEL   3
`define FCPC_BIT_HB4_EN       0
`define FCPC_BIT_POS_POL      4
`define FCPC_BIT_POS_ON       5
`define FCPC_BIT_NEG_POL      6
`define FCPC_BIT_NEG_ON       7
`define FCPC_CURSRC_MASK      8'hf3
`define FCPC_SEL_MASK         8'h1f

// reset values
`define FCPC_RST_BYTE         8'h00
`define FCPC_RST_SEL          5'h00
`define FCPC_RST_CTRL         4'h0

// pin codes that double as analog inputs start here
`define FCPC_PIN_ANALOG_BASE  5'h08

// timing
`define FCPC_CLK_NS           5
`define FCPC_TOGGLE_HALF_NS   1250
`define FCPC_TOGGLE_HALF_CYC  (`FCPC_TOGGLE_HALF_NS / `FCPC_CLK_NS)
`define FCPC_START_DLY_NS     2000
`define FCPC_START_DLY_CYC    (`FCPC_START_DLY_NS / `FCPC_CLK_NS)
`define FCPC_MS_NS            1000000

// bus responses
`define FCPC_RESP_OKAY        2'h0
`define FCPC_RESP_SLVERR      2'h2

`endif

/* File: logic/fcpc_pkg.sv */
// types of the fast conversion and pin block
package fcpc_pkg;

  typedef enum logic [1:0] {
    FS_IDLE = 2'h1,
    FS_WAIT = 2'h2
  } fcpc_start_t;

  typedef enum logic [1:0] {
    DRV_TRISTATE = 2'h0,
    DRV_LOW      = 2'h1,
    DRV_TOGGLE   = 2'h2,
    DRV_HIGH     = 2'h3
  } fcpc_drive_t;

  typedef struct packed {
    fcpc_start_t start_state;
    logic        aw_have;
    logic [11:0] aw_addr;
    logic        w_have;
    logic [7:0]  w_data;
    logic        w_strb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic [4:0]  neg_sel;
    logic [4:0]  pos_sel;
    logic [3:0]  fast_ctrl;
    logic        cont_prev;
    logic        hb4_en;
    logic [7:0]  cursrc_stage;
    logic [7:0]  cursrc_act;
    logic [7:0]  pin_drive;
    logic [7:0]  rd_ptr;
    logic [7:0]  dbg_cnt;
    logic [17:0] ms_cnt;
    logic [7:0]  tog_cnt;
    logic        tog;
    logic [8:0]  start_cnt;
    logic        conv_start;
    logic [4:0]  pin_out;
    logic [4:0]  pin_oe;
  } fcpc_state_t;

endpackage : fcpc_pkg

/* File: logic/fcpc_regs.sv */
// register bank and pin logic of the fast conversion path
//
// Notes on behaviour
// [RULE1] two 5-bit fast selects, reset zero
// [RULE2] bit 0 continuous; results pushed if channel set
// [RULE3] bits 1-3 channels; start after rise/command
// [RULE4] drive codes: tristate, low, 400kHz toggle, high
// [RULE5] pins 4, 5 heartbeat; alert holds low
// [RULE6] overcurrent enable makes pin 5 heartbeat
// [RULE7] pin 4 heartbeat enable overrides drive field
// [RULE8] source polarity and on bits, 250uA
// [RULE9] source connects only while converting
// [RULE10] pin 5 register applies on drive write
// [RULE11] host keeps 1ms between drive, control writes
// [RULE12] host rewrites four bytes per open-wire step
// [RULE13] tristate pin serves as analog input
// [RULE14] 8-bit indirect read pointer
// [RULE15] debug counter counts ms, clears per cycle
// [RULE16] counter typically reaches 100 or 17
// [RULE17] select codes decode, reserved codes flagged
// [RULE18] aux channel converts one selected pair
// [RULE19] host leaves selects alone while running
// [RULE20] unused bits ignore writes, read zero
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fcpc_defs.svh"

module fcpc_regs #(
  parameter int MS_TICK_CYCLES = `FCPC_MS_NS / `FCPC_CLK_NS
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  // axi4-lite write response
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  // axi4-lite read
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [11:0] s_axi_araddr_in,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  // core status, same clock
  input  wire logic        alert_unmasked_in,
  input  wire logic        oc_cmp_en_in,
  input  wire logic        oc_alert_in,
  input  wire logic        adc_attached_in,
  input  wire logic        start_conv_cmd_in,
  input  wire logic        core_cycle_done_in,
  // fast conversion control
  output logic [4:0]       fast_neg_input_sel_out,
  output logic [4:0]       fast_pos_input_sel_out,
  output logic             fast_cont_conv_en_out,
  output logic             fast_aux_ch_sel_out,
  output logic             fast_first_ch_sel_out,
  output logic             fast_second_ch_sel_out,
  output logic             fifo_push_en_out,
  output logic             fast_conv_start_out,
  output logic             neg_sel_reserved_out,
  output logic             pos_sel_reserved_out,
  output logic [7:0]       indirect_read_ptr_out,
  // open-wire current sources
  output logic             pos_src_on_out,
  output logic             pos_src_polarity_out,
  output logic             neg_src_on_out,
  output logic             neg_src_polarity_out,
  // general-purpose pins 1 to 5
  output logic [4:0]       pin_out,
  output logic [4:0]       pin_oe_out,
  output logic [4:0]       pin_analog_avail_out
);

  fcpc_pkg::fcpc_state_t state_reg;
  fcpc_pkg::fcpc_state_t state_next;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_go;

  // only the listed word addresses answer okay
  function automatic logic fcpc_mapped(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr[1:0] == 2'h0 && addr[11:10] == 2'h0)
    begin
      case (addr[9:2])
        `FCPC_IDX_DEBUG_CNT, `FCPC_IDX_HB4_CTRL, `FCPC_IDX_CURSRC_PIN5,
        `FCPC_IDX_PIN_DRIVE, `FCPC_IDX_FAST_NEG, `FCPC_IDX_FAST_POS,
        `FCPC_IDX_FAST_CTRL, `FCPC_IDX_RD_PTR: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    return hit;
  endfunction : fcpc_mapped

  // returns {oe, level}
  function automatic logic [1:0] fcpc_drive(input logic [1:0] code, input logic tog);
    logic [1:0] res;
    case (fcpc_pkg::fcpc_drive_t'(code))
      fcpc_pkg::DRV_LOW:    res = 2'h2;
      fcpc_pkg::DRV_TOGGLE: res = {1'b1, tog};
      fcpc_pkg::DRV_HIGH:   res = 2'h3;
      default:              res = 2'h0;
    endcase
    return res;
  endfunction : fcpc_drive

  // codes 21 and 24 to 31 select nothing
  function automatic logic fcpc_reserved(input logic [4:0] code);
    return (code == 5'h15) || (code[4:3] == 2'h3);
  endfunction : fcpc_reserved

  assign s_axi_awready_out = !state_reg.aw_have && !state_reg.bvalid;
  assign s_axi_wready_out  = !state_reg.w_have && !state_reg.bvalid;
  assign s_axi_arready_out = !state_reg.rvalid;
  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take  = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
  assign wr_go   = (state_reg.aw_have || aw_take) && (state_reg.w_have || w_take);

  always_comb
  begin
    state_next = state_reg;
    state_next.conv_start = 1'b0;
    state_next.cont_prev  = state_reg.fast_ctrl[`FCPC_BIT_CONT_EN];
    if (aw_take)
    begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = s_axi_awaddr_in;
    end
    if (w_take)
    begin
      state_next.w_have  = 1'b1;
      state_next.w_data  = s_axi_wdata_in[7:0];
      state_next.w_strb0 = s_axi_wstrb_in[0];
    end
    if (state_reg.bvalid && s_axi_bready_in)
      state_next.bvalid = 1'b0;
    // address and data may come in either order
    if (wr_go)
    begin
      state_next.aw_have = 1'b0;
      state_next.w_have  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = fcpc_mapped(state_next.aw_addr) ? `FCPC_RESP_OKAY
                                                           : `FCPC_RESP_SLVERR;
      if (fcpc_mapped(state_next.aw_addr) && state_next.w_strb0)
      begin
        case (state_next.aw_addr[9:2])
          `FCPC_IDX_HB4_CTRL:
            state_next.hb4_en = state_next.w_data[`FCPC_BIT_HB4_EN];
          // [RULE10] held until drive write
          `FCPC_IDX_CURSRC_PIN5:
            state_next.cursrc_stage = state_next.w_data & `FCPC_CURSRC_MASK;
          `FCPC_IDX_PIN_DRIVE:
          begin
            state_next.pin_drive  = state_next.w_data;
            state_next.cursrc_act = state_reg.cursrc_stage;
          end
          // [RULE1] fast selects
          `FCPC_IDX_FAST_NEG: state_next.neg_sel = state_next.w_data[4:0];
          `FCPC_IDX_FAST_POS: state_next.pos_sel = state_next.w_data[4:0];
          `FCPC_IDX_FAST_CTRL: state_next.fast_ctrl = state_next.w_data[3:0];
          // [RULE14] indirect pointer
          `FCPC_IDX_RD_PTR: state_next.rd_ptr = state_next.w_data;
          default: ;
        endcase
      end
    end
    if (state_reg.rvalid && s_axi_rready_in)
      state_next.rvalid = 1'b0;
    if (ar_take)
    begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = fcpc_mapped(s_axi_araddr_in) ? `FCPC_RESP_OKAY : `FCPC_RESP_SLVERR;
      // [RULE20] unused bits read zero
      case (s_axi_araddr_in[9:2])
        `FCPC_IDX_DEBUG_CNT:   state_next.rdata = state_reg.dbg_cnt;
        `FCPC_IDX_HB4_CTRL:    state_next.rdata = {7'h00, state_reg.hb4_en};
        `FCPC_IDX_CURSRC_PIN5: state_next.rdata = state_reg.cursrc_stage;
        `FCPC_IDX_PIN_DRIVE:   state_next.rdata = state_reg.pin_drive;
        `FCPC_IDX_FAST_NEG:    state_next.rdata = {3'h0, state_reg.neg_sel};
        `FCPC_IDX_FAST_POS:    state_next.rdata = {3'h0, state_reg.pos_sel};
        `FCPC_IDX_FAST_CTRL:   state_next.rdata = {4'h0, state_reg.fast_ctrl};
        `FCPC_IDX_RD_PTR:      state_next.rdata = state_reg.rd_ptr;
        default:               state_next.rdata = `FCPC_RST_BYTE;
      endcase
      if (!fcpc_mapped(s_axi_araddr_in))
        state_next.rdata = `FCPC_RST_BYTE;
    end
    // [RULE4] 400kHz toggle base
    if (state_reg.tog_cnt == 8'(`FCPC_TOGGLE_HALF_CYC - 1))
    begin
      state_next.tog_cnt = 8'h00;
      state_next.tog     = !state_reg.tog;
    end
    else
      state_next.tog_cnt = state_reg.tog_cnt + 8'h01;
    // [RULE3] delayed start after continuous enable rises
    case (state_reg.start_state)
      fcpc_pkg::FS_IDLE:
      begin
        if (state_reg.fast_ctrl[`FCPC_BIT_CONT_EN] && !state_reg.cont_prev)
        begin
          state_next.start_state = fcpc_pkg::FS_WAIT;
          state_next.start_cnt   = 9'h000;
        end
      end
      fcpc_pkg::FS_WAIT:
      begin
        state_next.start_cnt = state_reg.start_cnt + 9'h001;
        if (state_reg.start_cnt == 9'(`FCPC_START_DLY_CYC - 1))
        begin
          state_next.conv_start  = 1'b1;
          state_next.start_state = fcpc_pkg::FS_IDLE;
        end
      end
      default: state_next.start_state = fcpc_pkg::FS_IDLE;
    endcase
    // [RULE3] command start is immediate
    if (start_conv_cmd_in)
      state_next.conv_start = 1'b1;
    // [RULE15] [RULE16] millisecond count, cleared per core cycle
    if (state_reg.ms_cnt == 18'(MS_TICK_CYCLES - 1))
    begin
      state_next.ms_cnt = 18'h00000;
      if (state_reg.dbg_cnt != 8'hff)
        state_next.dbg_cnt = state_reg.dbg_cnt + 8'h01;
    end
    else
      state_next.ms_cnt = state_reg.ms_cnt + 18'h00001;
    if (core_cycle_done_in)
    begin
      state_next.ms_cnt  = 18'h00000;
      state_next.dbg_cnt = `FCPC_RST_BYTE;
    end
    // [RULE4] pins 1 to 4 from the drive register
    for (int i = 0; i < 4; i++)
      {state_next.pin_oe[i], state_next.pin_out[i]} =
        fcpc_drive(state_reg.pin_drive[2*i +: 2], state_reg.tog);
    {state_next.pin_oe[4], state_next.pin_out[4]} =
      fcpc_drive(state_reg.cursrc_act[1:0], state_reg.tog);
    // [RULE5] [RULE7] pin 4 heartbeat overrides field
    if (state_reg.hb4_en)
    begin
      state_next.pin_oe[3]  = 1'b1;
      state_next.pin_out[3] = state_reg.tog && !alert_unmasked_in;
    end
    // [RULE6] overcurrent heartbeat overrides pin 5 field
    if (oc_cmp_en_in)
    begin
      state_next.pin_oe[4]  = 1'b1;
      state_next.pin_out[4] = state_reg.tog && !oc_alert_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg              <= '0;
      state_reg.start_state  <= fcpc_pkg::FS_IDLE;
      state_reg.neg_sel      <= `FCPC_RST_SEL;
      state_reg.pos_sel      <= `FCPC_RST_SEL;
      state_reg.fast_ctrl    <= `FCPC_RST_CTRL;
      state_reg.cursrc_stage <= `FCPC_RST_BYTE;
      state_reg.cursrc_act   <= `FCPC_RST_BYTE;
      state_reg.pin_drive    <= `FCPC_RST_BYTE;
    end
    else
      state_reg <= state_next;
  end

  assign s_axi_bvalid_out = state_reg.bvalid;
  assign s_axi_bresp_out  = state_reg.bresp;
  assign s_axi_rvalid_out = state_reg.rvalid;
  assign s_axi_rdata_out  = {24'h000000, state_reg.rdata};
  assign s_axi_rresp_out  = state_reg.rresp;

  // [RULE18] one differential pair for the aux channel
  assign fast_neg_input_sel_out = state_reg.neg_sel;
  assign fast_pos_input_sel_out = state_reg.pos_sel;
  // [RULE17] reserved codes flagged to the mux
  assign neg_sel_reserved_out   = fcpc_reserved(state_reg.neg_sel);
  assign pos_sel_reserved_out   = fcpc_reserved(state_reg.pos_sel);
  assign fast_cont_conv_en_out  = state_reg.fast_ctrl[`FCPC_BIT_CONT_EN];
  assign fast_aux_ch_sel_out    = state_reg.fast_ctrl[`FCPC_BIT_AUX_SEL];
  assign fast_first_ch_sel_out  = state_reg.fast_ctrl[`FCPC_BIT_FIRST_SEL];
  assign fast_second_ch_sel_out = state_reg.fast_ctrl[`FCPC_BIT_SECOND_SEL];
  // [RULE2] fifo only with a channel selected
  assign fifo_push_en_out       = state_reg.fast_ctrl[`FCPC_BIT_CONT_EN] &&
                                  (|state_reg.fast_ctrl[3:1]);
  assign fast_conv_start_out    = state_reg.conv_start;
  assign indirect_read_ptr_out  = state_reg.rd_ptr;

  // [RULE8] polarity and on bits; [RULE9] gated by conversion
  assign pos_src_polarity_out = state_reg.cursrc_act[`FCPC_BIT_POS_POL];
  assign neg_src_polarity_out = state_reg.cursrc_act[`FCPC_BIT_NEG_POL];
  assign pos_src_on_out = state_reg.cursrc_act[`FCPC_BIT_POS_ON] && adc_attached_in;
  assign neg_src_on_out = state_reg.cursrc_act[`FCPC_BIT_NEG_ON] && adc_attached_in;

  assign pin_out    = state_reg.pin_out;
  assign pin_oe_out = state_reg.pin_oe;

  // [RULE13] undriven pin doubles as analog input
  always_comb
  begin
    for (int i = 0; i < 5; i++)
      pin_analog_avail_out[i] = !state_reg.pin_oe[i] &&
        ((state_reg.neg_sel == `FCPC_PIN_ANALOG_BASE + 5'(i)) ||
         (state_reg.pos_sel == `FCPC_PIN_ANALOG_BASE + 5'(i)));
  end

  localparam int START_MAX = `FCPC_START_DLY_CYC + 3;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_cont_rise;
    $rose(state_reg.fast_ctrl[`FCPC_BIT_CONT_EN]) && !start_conv_cmd_in;
  endsequence
  sequence s_start_seen;
    ##[1:START_MAX] fast_conv_start_out;
  endsequence
  a_cont_start_delay: assert property (s_cont_rise |-> s_start_seen) // [RULE3]
    else $error("no fast start after continuous enable rose");
  a_cmd_start_next: assert property (start_conv_cmd_in |=> fast_conv_start_out) // [RULE3]
    else $error("command did not start conversion");
  a_pend_hold: assert property ( // [RULE10]
    wr_go && state_next.aw_addr[9:2] == `FCPC_IDX_CURSRC_PIN5 &&
    state_next.aw_addr[11:10] == 2'h0 |=> $stable(state_reg.cursrc_act))
    else $error("pin 5 register applied without drive write");
  a_pend_apply: assert property ( // [RULE10]
    wr_go && state_next.w_strb0 && state_next.aw_addr == 12'(`FCPC_IDX_PIN_DRIVE * 4)
    |=> state_reg.cursrc_act == $past(state_reg.cursrc_stage))
    else $error("staged pin 5 value not applied");
  a_hb4_stop: assert property ( // [RULE7]
    state_reg.hb4_en && alert_unmasked_in |=> pin_oe_out[3] && !pin_out[3])
    else $error("pin 4 heartbeat kept toggling on alert");
  a_hb5_stop: assert property ( // [RULE6]
    oc_cmp_en_in && oc_alert_in |=> pin_oe_out[4] && !pin_out[4])
    else $error("pin 5 heartbeat kept toggling on alert");
  a_tog_half: assert property ( // [RULE4]
    $changed(state_reg.tog) |=> $stable(state_reg.tog) [*8])
    else $error("toggle base changed too soon");
  a_pin1_high: assert property ( // [RULE4]
    state_reg.pin_drive[1:0] == 2'h3 |=> pin_oe_out[0] && pin_out[0])
    else $error("pin 1 not driven high");
  a_src_gate: assert property ( // [RULE9]
    !adc_attached_in |-> !pos_src_on_out && !neg_src_on_out)
    else $error("current source on while converter detached");
  a_dbg_clear: assert property (core_cycle_done_in |=> state_reg.dbg_cnt == 8'h00) // [RULE15]
    else $error("debug counter not cleared");
  a_sel_unused: assert property ( // [RULE20]
    ar_take && s_axi_araddr_in == 12'(`FCPC_IDX_FAST_NEG * 4) |=> s_axi_rdata_out[31:5] == '0)
    else $error("select upper bits not zero");
  a_read_answer: assert property (ar_take |=> s_axi_rvalid_out) // [RULE14]
    else $error("read not answered next cycle");
endmodule : fcpc_regs

/* File: tb/fcpc_host.sv */
// host model: axi4-lite master that keeps the register write spacing
`timescale 1ns/1ps
module fcpc_host #(
  parameter int SPACE_CYC = 200000
) (
  // clock
  input  wire logic        clock_in,
  // slave answers
  input  wire logic        awready_in,
  input  wire logic        wready_in,
  input  wire logic        bvalid_in,
  input  wire logic [1:0]  bresp_in,
  input  wire logic        arready_in,
  input  wire logic        rvalid_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in
);
  logic        awvalid = 1'h0;
  logic        wvalid  = 1'h0;
  logic        bready  = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready  = 1'h0;
  logic [11:0] awaddr  = 12'h000;
  logic [11:0] araddr  = 12'h000;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hf;
  int          cyc     = 0;
  int          last_f2 = -SPACE_CYC;
  int          last_f5 = -SPACE_CYC;

  always @(posedge clock_in) cyc <= cyc + 1;

  task automatic write(input logic [7:0] idx, input logic [7:0] val, output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    if (idx == 8'hf2) while (cyc - last_f5 < SPACE_CYC) @(posedge clock_in);
    if (idx == 8'hf5) while (cyc - last_f2 < SPACE_CYC) @(posedge clock_in);
    aw_done = 1'h0;
    w_done = 1'h0;
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, val};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_done && w_done))
    begin
      @(posedge clock_in);
      if (awvalid && awready_in)
      begin
        aw_done = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready_in)
      begin
        w_done = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge clock_in); while (bvalid_in !== 1'h1);
    resp = bresp_in;
    bready <= 1'h0;
    if (idx == 8'hf2) last_f2 = cyc;
    if (idx == 8'hf5) last_f5 = cyc;
    // idle edge so the next request never lands in this time step
    @(posedge clock_in);
  endtask : write

  task automatic read(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clock_in); while (arready_in !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clock_in); while (rvalid_in !== 1'h1);
    data = rdata_in;
    resp = rresp_in;
    rready <= 1'h0;
    @(posedge clock_in);
  endtask : read
endmodule : fcpc_host

/* File: tb/tb_top.sv */
// self-checking bench of the fast conversion and pin register block
`timescale 1ns/1ps
module tb_top;
  localparam int MS_CYC = 20;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        alert = 1'h0, oc_en = 1'h0, oc_alert = 1'h0;
  logic        attached = 1'h0, cmd = 1'h0, cyc_done = 1'h0;
  logic        awr, wr, bv, arr, rv, cont, auxs, s1, s2, push, start;
  logic        nres, pres, pon, ppol, non, npol;
  logic [1:0]  br, rr;
  logic [31:0] rd;
  logic [4:0]  nsel, psel, pin, oe, avail;
  logic [7:0]  ptr;
  logic [7:0]  regs [8] = '{8'hd5, 8'he8, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hfc};
  int          n_fail = 0;
  int          check_count = 0;

  always #2.5 clk = ~clk;

  fcpc_regs #(.MS_TICK_CYCLES(MS_CYC)) DUT (
    .clock_in(clk), .rst_n_in(rst_n),
    .s_axi_awvalid_in(host.awvalid), .s_axi_awready_out(awr), .s_axi_awaddr_in(host.awaddr),
    .s_axi_wvalid_in(host.wvalid), .s_axi_wready_out(wr), .s_axi_wdata_in(host.wdata),
    .s_axi_wstrb_in(host.wstrb), .s_axi_bvalid_out(bv), .s_axi_bready_in(host.bready),
    .s_axi_bresp_out(br), .s_axi_arvalid_in(host.arvalid), .s_axi_arready_out(arr),
    .s_axi_araddr_in(host.araddr), .s_axi_rvalid_out(rv), .s_axi_rready_in(host.rready),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
    .alert_unmasked_in(alert), .oc_cmp_en_in(oc_en), .oc_alert_in(oc_alert),
    .adc_attached_in(attached), .start_conv_cmd_in(cmd), .core_cycle_done_in(cyc_done),
    .fast_neg_input_sel_out(nsel), .fast_pos_input_sel_out(psel),
    .fast_cont_conv_en_out(cont), .fast_aux_ch_sel_out(auxs),
    .fast_first_ch_sel_out(s1), .fast_second_ch_sel_out(s2),
    .fifo_push_en_out(push), .fast_conv_start_out(start),
    .neg_sel_reserved_out(nres), .pos_sel_reserved_out(pres),
    .indirect_read_ptr_out(ptr), .pos_src_on_out(pon), .pos_src_polarity_out(ppol),
    .neg_src_on_out(non), .neg_src_polarity_out(npol),
    .pin_out(pin), .pin_oe_out(oe), .pin_analog_avail_out(avail)
  );

  fcpc_host #(.SPACE_CYC(40)) host (
    .clock_in(clk), .awready_in(awr), .wready_in(wr), .bvalid_in(bv), .bresp_in(br),
    .arready_in(arr), .rvalid_in(rv), .rdata_in(rd), .rresp_in(rr)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] v);
    logic [1:0] r;
    host.write(idx, v, r);
    chk({30'h0, r}, 32'h0);
  endtask : wr_reg

  task automatic chk_rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    host.read(idx, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask : chk_rd

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic t_reset();
    logic [1:0] r;
    // counter read first, before its first tick
    foreach (regs[i]) chk_rd(regs[i], 32'h0, 2'h0);
    chk_rd(8'h10, 32'h0, 2'h2);
    host.write(8'h10, 8'h55, r);
    chk({30'h0, r}, 32'h2);
    chk(oe, 5'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_sel();
    wr_reg(8'hf3, 8'hff);
    chk_rd(8'hf3, 32'h1f, 2'h0);
    chk({nsel, nres}, {5'h1f, 1'h1});
    for (int c = 0; c < 32; c++)
    begin
      wr_reg(8'hf4, 8'(c));
      chk(psel, c[4:0]);
      chk(pres, c == 21 || c >= 24);
    end
    wr_reg(8'he8, 8'hff);
    chk_rd(8'he8, 32'h01, 2'h0);
    wr_reg(8'he8, 8'h00);
    wr_reg(8'hfc, 8'ha5);
    chk_rd(8'hfc, 32'ha5, 2'h0);
    chk(ptr, 8'ha5);
    $display("select test done");
  endtask : t_sel

  task automatic t_stage();
    wr_reg(8'hf1, 8'hff);
    chk_rd(8'hf1, 32'hf3, 2'h0);
    chk({ppol, npol, oe[4]}, 3'h0);
    wr_reg(8'hf2, 8'h00);
    wr_reg(8'hf3, 8'h08);
    wr_reg(8'hf4, 8'h09);
    chk({ppol, npol, oe[4], pin[4]}, 4'hf);
    chk({pon, non}, 2'h0);
    attached <= 1'h1;
    tick(1);
    chk({pon, non}, 2'h3);
    wr_reg(8'hf1, 8'ha0);
    wr_reg(8'hf2, 8'h00);
    tick(1);
    chk({ppol, npol, oe[4], pon, non}, 5'h03);
    attached <= 1'h0;
    tick(1);
    chk({pon, non}, 2'h0);
    $display("staging test done");
  endtask : t_stage

  task automatic t_drive();
    logic [3:0] a;
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(8'hf2, {4{k[1:0]}});
      tick(2);
      chk(oe[3:0], k == 0 ? 4'h0 : 4'hf);
      chk(avail, k == 0 ? 5'h03 : 5'h00);
      if (k != 2 && k != 0) chk(pin[3:0], k == 1 ? 4'h0 : 4'hf);
      a = pin[3:0];
      tick(250);
      if (k == 2) chk(pin[3:0], 4'(~a));
      if (k == 2) chk(a, a[0] ? 4'hf : 4'h0);
    end
    $display("drive test done");
  endtask : t_drive

  task automatic t_beat();
    logic a;
    wr_reg(8'hf2, 8'hc0);
    wr_reg(8'he8, 8'h01);
    tick(2);
    a = pin[3];
    tick(250);
    chk({oe[3], pin[3]}, {1'h1, ~a});
    alert <= 1'h1;
    for (int i = 0; i < 6; i++)
    begin
      tick(50);
      chk({oe[3], pin[3]}, 2'h2);
    end
    wr_reg(8'he8, 8'h00);
    tick(2);
    chk({oe[3], pin[3]}, 2'h3);
    oc_en <= 1'h1;
    tick(2);
    a = pin[4];
    tick(250);
    chk({oe[4], pin[4]}, {1'h1, ~a});
    oc_alert <= 1'h1;
    for (int i = 0; i < 6; i++)
    begin
      tick(50);
      chk({oe[4], pin[4]}, 2'h2);
    end
    {alert, oc_alert, oc_en} <= 3'h0;
    tick(2);
    chk(oe[4], 1'h0);
    $display("heartbeat test done");
  endtask : t_beat

  task automatic t_fast();
    int n;
    wr_reg(8'hf5, 8'hf1);
    chk_rd(8'hf5, 32'h01, 2'h0);
    chk({cont, push}, 2'h2);
    for (n = 0; n < 600 && start !== 1'h1; n++) tick(1);
    chk(n > 350 && n < 450, 1'h1);
    tick(1);
    chk(start, 1'h0);
    for (int b = 1; b < 4; b++)
    begin
      wr_reg(8'hf5, 8'h01 | (8'h01 << b));
      chk({s2, s1, auxs, push}, {3'(1 << (b - 1)), 1'h1});
      wr_reg(8'hf5, 8'h01 << b);
      chk({cont, push, start}, 3'h0);
    end
    cmd <= 1'h1;
    tick(1);
    cmd <= 1'h0;
    tick(1);
    chk(start, 1'h1);
    $display("fast test done");
  endtask : t_fast

  task automatic t_dbg();
    cyc_done <= 1'h1;
    tick(1);
    cyc_done <= 1'h0;
    tick(5 * MS_CYC + 3);
    chk_rd(8'hd5, 32'h05, 2'h0);
    wr_reg(8'hd5, 8'h00);
    chk_rd(8'hd5, 32'h05, 2'h0);
    // counter reaches a full measuring cycle
    tick(95 * MS_CYC);
    chk_rd(8'hd5, 32'h64, 2'h0);
    $display("debug counter test done");
  endtask : t_dbg

  initial
  begin
    tick(10);
    rst_n <= 1'h1;
    tick(1);
    t_reset();
    t_sel();
    t_stage();
    t_drive();
    t_beat();
    t_fast();
    t_dbg();
    stop_test();
  end

  // whole run is a few thousand cycles; this is ample margin
  initial
  begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule : tb_top
